// file: fpg_pin_model.sv
// fpg_pin_model: external circuitry seen by one gpio port
`timescale 1ns/100ps
module fpg_pin_model #(
  parameter int W = 8
) (
  input wire logic hclk,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] pull_en,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] lvl
);
  logic [W-1:0] flt_r = '0;

  // an undriven pin toggles so a stale level never passes for valid
  always @(posedge hclk) begin
    flt_r <= ~flt_r;
  end

  // external drive is weak: the port's own driver wins
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe[i]) lvl[i] = out[i];
      else if (ext_en[i]) lvl[i] = ext_val[i];
      else if (pull_en[i]) lvl[i] = 1'b1;
      else lvl[i] = flt_r[i];
    end
  end
endmodule : fpg_pin_model

// file: fpg_pkg.sv
// fpg_pkg: register map, reset values and pin bundles of the four-port gpio
package fpg_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] FPG_IDX_PORT_A_LATCH = 6'h00;
  localparam logic [5:0] FPG_IDX_PORT_B_LATCH = 6'h01;
  localparam logic [5:0] FPG_IDX_PORT_C_LATCH = 6'h02;
  localparam logic [5:0] FPG_IDX_PORT_D_LATCH = 6'h03;
  localparam logic [5:0] FPG_IDX_PORT_A_DIR = 6'h04;
  localparam logic [5:0] FPG_IDX_PORT_B_DIR = 6'h05;
  localparam logic [5:0] FPG_IDX_PORT_C_DIR = 6'h06;
  localparam logic [5:0] FPG_IDX_PORT_D_DIR = 6'h07;
  localparam logic [5:0] FPG_IDX_OPTION = 6'h1D;
  localparam logic [5:0] FPG_IDX_KEYPAD_EN = 6'h1E;
  localparam int FPG_IDX_LSB = 2;

  // ---------------------------------------------------------------
  // widths, field positions, reset values
  // ---------------------------------------------------------------
  localparam int FPG_WIDE = 8;
  localparam int FPG_NARROW = 5;
  localparam int FPG_OPT_PA_BIT = 0;
  localparam int FPG_OPT_PB_BIT = 1;
  localparam int FPG_OPT_PC_BIT = 2;
  localparam int FPG_OPT_LED_BIT = 5;
  localparam logic [7:0] FPG_OPT_MASK = 8'h27;
  localparam logic [7:0] FPG_OPT_RESET = 8'h20;
  localparam logic [7:0] FPG_DIR_RESET = 8'h00;
  localparam logic [7:0] FPG_KEYPAD_RESET = 8'h00;
  localparam logic [31:0] FPG_RDATA_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // bus slave states and pin bundles
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FPG_ST_IDLE = 2'b00,
    FPG_ST_WRITE = 2'b01,
    FPG_ST_STALL = 2'b10
  } fpg_state_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_en;
  } fpg_pin8_t;

  typedef struct packed {
    logic [4:0] out;
    logic [4:0] oe;
    logic [4:0] pull_en;
  } fpg_pin5_t;

endpackage : fpg_pkg

// file: fpg_port.sv
// fpg_port: one port's latch, direction, pin sampler and pull-up control
`timescale 1ns/100ps
module fpg_port #(
  parameter int W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr_latch,
  input wire logic wr_dir,
  input wire logic [W-1:0] wdata,
  input wire logic [W-1:0] pin_in,
  input wire logic [W-1:0] pullup_req,
  output logic [W-1:0] latch_q,
  output logic [W-1:0] dir_q,
  output logic [W-1:0] pullup_q,
  output logic [W-1:0] rd_val
);
  import fpg_pkg::*;

  logic [W-1:0] sync1_r;
  logic [W-1:0] sync2_r;

  // ---------------------------------------------------------------
  // data latch: no reset, contents survive a system reset
  // ---------------------------------------------------------------
  always_ff @(posedge hclk) begin
    if (wr_latch) begin
      latch_q <= wdata; // R3 R6 R7
    end
  end

  // ---------------------------------------------------------------
  // direction: one enables the pin driver
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_q <= FPG_DIR_RESET[W-1:0]; // R2
    end else if (wr_dir) begin
      dir_q <= wdata; // R1 R17
    end
  end

  // pins are asynchronous to hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // pull-ups only on pins acting as inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pullup_q <= '0;
    end else begin
      pullup_q <= pullup_req & ~dir_q; // R9 R10 R11 R14
    end
  end

  // ---------------------------------------------------------------
  // read value: latch for outputs, sampled pin for inputs
  // ---------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_rd
    assign rd_val[i] = dir_q[i] ? latch_q[i] : sync2_r[i]; // R4 R5
  end

endmodule : fpg_port

// file: fpg_top.sv
// fpg_top: ahb-lite register slave and four bidirectional gpio ports
//
// What this block does
// R1 - direction one drives pin, zero floats it
// R2 - reset clears all direction bits
// R3 - reset leaves data latches unchanged
// R4 - output bits read back the latch
// R5 - input bits read back the pin
// R6 - latch writes always take effect
// R7 - latch write never drives an input pin
// R8 - software loads latch before setting direction
// R9 - port a pull-ups on inputs when enabled
// R10 - port b pull-ups on inputs when enabled
// R11 - port c pull-ups on inputs when enabled
// R12 - one option bit selects led drive
// R13 - ports a, b, d eight pins; c five
// R14 - keypad-enabled port d inputs get pull-ups
// R15 - keypad enable bits make pins interrupt inputs
// R16 - port c upper bits read zero
// R17 - direction reads return last written value
`timescale 1ns/100ps
module fpg_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] pa_pin_in,
  input wire logic [7:0] pb_pin_in,
  input wire logic [4:0] pc_pin_in,
  input wire logic [7:0] pd_pin_in,
  output fpg_pkg::fpg_pin8_t pa_pins,
  output fpg_pkg::fpg_pin8_t pb_pins,
  output fpg_pkg::fpg_pin5_t pc_pins,
  output fpg_pkg::fpg_pin8_t pd_pins,
  output logic led_drive_select,
  output logic [7:0] port_d_keypad_irq_enables
);
  import fpg_pkg::*;

  // ---------------------------------------------------------------
  // bus slave state
  // ---------------------------------------------------------------
  fpg_state_t st_r;
  logic [5:0] addr_r;
  logic accept;
  logic wr_en;
  logic [5:0] rd_idx;
  logic [7:0] rd_byte;
  logic [7:0] port_option_control_r;
  logic [7:0] port_d_keypad_irq_enable_reg_r;
  logic [7:0] pa_rd;
  logic [7:0] pb_rd;
  logic [4:0] pc_rd;
  logic [7:0] pd_rd;

  assign accept = hsel & htrans[1] & hready;
  assign wr_en = (st_r == FPG_ST_WRITE);
  // a read right behind a write waits one cycle so it sees the new value
  assign rd_idx = (st_r == FPG_ST_STALL) ? addr_r :
                  haddr[FPG_IDX_LSB +: 6];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= FPG_ST_IDLE;
      hreadyout <= 1'b1;
    end else begin
      case (st_r)
        FPG_ST_IDLE, FPG_ST_WRITE: begin
          if (accept && hwrite) begin
            st_r <= FPG_ST_WRITE;
          end else if (accept && st_r == FPG_ST_WRITE) begin
            st_r <= FPG_ST_STALL;
            hreadyout <= 1'b0;
          end else begin
            st_r <= FPG_ST_IDLE;
          end
        end
        FPG_ST_STALL: begin
          st_r <= FPG_ST_IDLE;
          hreadyout <= 1'b1;
        end
        default: begin
          st_r <= FPG_ST_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= '0;
    end else if (accept) begin
      addr_r <= haddr[FPG_IDX_LSB +: 6];
    end
  end

  // every transfer ends okay; unmapped words read zero, writes vanish
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  always_comb begin
    case (rd_idx)
      FPG_IDX_PORT_A_LATCH: rd_byte = pa_rd; // R4 R5
      FPG_IDX_PORT_B_LATCH: rd_byte = pb_rd;
      FPG_IDX_PORT_C_LATCH: rd_byte = {3'h0, pc_rd}; // R16
      FPG_IDX_PORT_D_LATCH: rd_byte = pd_rd;
      FPG_IDX_PORT_A_DIR: rd_byte = pa_pins.oe; // R17
      FPG_IDX_PORT_B_DIR: rd_byte = pb_pins.oe;
      FPG_IDX_PORT_C_DIR: rd_byte = {3'h0, pc_pins.oe}; // R16
      FPG_IDX_PORT_D_DIR: rd_byte = pd_pins.oe;
      FPG_IDX_OPTION: rd_byte = port_option_control_r;
      FPG_IDX_KEYPAD_EN: rd_byte = port_d_keypad_irq_enable_reg_r;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= FPG_RDATA_RESET;
    end else if ((accept && !hwrite && st_r != FPG_ST_WRITE) ||
                 st_r == FPG_ST_STALL) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  // ---------------------------------------------------------------
  // option and keypad enable registers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_option_control_r <= FPG_OPT_RESET;
    end else if (wr_en && addr_r == FPG_IDX_OPTION) begin
      port_option_control_r <= hwdata[7:0] & FPG_OPT_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_d_keypad_irq_enable_reg_r <= FPG_KEYPAD_RESET;
    end else if (wr_en && addr_r == FPG_IDX_KEYPAD_EN) begin
      port_d_keypad_irq_enable_reg_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_drive_select <= FPG_OPT_RESET[FPG_OPT_LED_BIT];
      port_d_keypad_irq_enables <= FPG_KEYPAD_RESET;
    end else begin
      led_drive_select <= port_option_control_r[FPG_OPT_LED_BIT]; // R12
      port_d_keypad_irq_enables <= port_d_keypad_irq_enable_reg_r; // R15
    end
  end

  // ---------------------------------------------------------------
  // the four ports
  // ---------------------------------------------------------------
  fpg_port #(.W(FPG_WIDE)) u_port_a ( // R13
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_latch(wr_en && addr_r == FPG_IDX_PORT_A_LATCH),
    .wr_dir(wr_en && addr_r == FPG_IDX_PORT_A_DIR),
    .wdata(hwdata[7:0]),
    .pin_in(pa_pin_in),
    .pullup_req({8{port_option_control_r[FPG_OPT_PA_BIT]}}), // R9
    .latch_q(pa_pins.out),
    .dir_q(pa_pins.oe),
    .pullup_q(pa_pins.pull_en),
    .rd_val(pa_rd)
  );

  fpg_port #(.W(FPG_WIDE)) u_port_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_latch(wr_en && addr_r == FPG_IDX_PORT_B_LATCH),
    .wr_dir(wr_en && addr_r == FPG_IDX_PORT_B_DIR),
    .wdata(hwdata[7:0]),
    .pin_in(pb_pin_in),
    .pullup_req({8{port_option_control_r[FPG_OPT_PB_BIT]}}), // R10
    .latch_q(pb_pins.out),
    .dir_q(pb_pins.oe),
    .pullup_q(pb_pins.pull_en),
    .rd_val(pb_rd)
  );

  // upper three data bits of port c simply do not exist
  fpg_port #(.W(FPG_NARROW)) u_port_c ( // R13 R16
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_latch(wr_en && addr_r == FPG_IDX_PORT_C_LATCH),
    .wr_dir(wr_en && addr_r == FPG_IDX_PORT_C_DIR),
    .wdata(hwdata[4:0]),
    .pin_in(pc_pin_in),
    .pullup_req({5{port_option_control_r[FPG_OPT_PC_BIT]}}), // R11
    .latch_q(pc_pins.out),
    .dir_q(pc_pins.oe),
    .pullup_q(pc_pins.pull_en),
    .rd_val(pc_rd)
  );

  // port d has no pull-up option; keypad enables request them
  fpg_port #(.W(FPG_WIDE)) u_port_d (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_latch(wr_en && addr_r == FPG_IDX_PORT_D_LATCH),
    .wr_dir(wr_en && addr_r == FPG_IDX_PORT_D_DIR),
    .wdata(hwdata[7:0]),
    .pin_in(pd_pin_in),
    .pullup_req(port_d_keypad_irq_enable_reg_r), // R14
    .latch_q(pd_pins.out),
    .dir_q(pd_pins.oe),
    .pullup_q(pd_pins.pull_en),
    .rd_val(pd_rd)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic rd_now;
  assign rd_now = accept && !hwrite && st_r != FPG_ST_WRITE;

  reset_dir_a: assert property ($rose(hresetn) |-> // R2
    pa_pins.oe == 8'h00 && pb_pins.oe == 8'h00 &&
    pc_pins.oe == 5'h00 && pd_pins.oe == 8'h00)
    else $error("direction not clear after reset");

  // case equality: a latch never written is unknown on both sides
  latch_keep_a: assert property ($rose(hresetn) |-> // R3
    pa_pins.out === $past(pa_pins.out))
    else $error("latch changed across reset");

  read_mux_a: assert property (rd_now && // R4
    haddr[FPG_IDX_LSB +: 6] == FPG_IDX_PORT_A_LATCH |=>
    hrdata[7:0] == (($past(pa_pins.out) & $past(pa_pins.oe)) |
                   ($past(pa_pin_in, 3) & ~$past(pa_pins.oe))))
    else $error("port a read value wrong");

  // a pin level needs two synchroniser edges before the read edge
  read_pin_a: assert property (rd_now && // R5
    haddr[FPG_IDX_LSB +: 6] == FPG_IDX_PORT_B_LATCH |=>
    (hrdata[7:0] & ~$past(pb_pins.oe)) ==
    ($past(pb_pin_in, 3) & ~$past(pb_pins.oe)))
    else $error("port b input read wrong");

  latch_write_a: assert property (wr_en && // R6
    addr_r == FPG_IDX_PORT_D_LATCH |=> pd_pins.out == $past(hwdata[7:0]))
    else $error("port d latch not written");

  input_quiet_a: assert property (wr_en && // R7
    addr_r == FPG_IDX_PORT_A_LATCH |=> $stable(pa_pins.oe))
    else $error("latch write moved a driver");

  drive_dir_a: assert property (wr_en && // R1
    addr_r == FPG_IDX_PORT_C_DIR |=> pc_pins.oe == $past(hwdata[4:0]))
    else $error("port c driver enable wrong");

  pullup_on_a: assert property (##1 pa_pins.pull_en == // R9
    ($past(pa_pins.oe) == 8'h00 ? {8{$past(
    port_option_control_r[FPG_OPT_PA_BIT])}} :
    ({8{$past(port_option_control_r[FPG_OPT_PA_BIT])}} &
    ~$past(pa_pins.oe))))
    else $error("port a pull-up wrong");

  pullup_b_a: assert property (pb_pins.oe != 8'h00 |=> // R10
    (pb_pins.pull_en & $past(pb_pins.oe)) == 8'h00)
    else $error("port b pull-up on output");

  pullup_c_a: assert property ( // R11
    port_option_control_r[FPG_OPT_PC_BIT] |=>
    pc_pins.pull_en == ~$past(pc_pins.oe))
    else $error("port c pull-up missing");

  led_sel_a: assert property (wr_en && addr_r == FPG_IDX_OPTION |=> // R12
    ##1 led_drive_select == $past(hwdata[FPG_OPT_LED_BIT], 2))
    else $error("led drive select wrong");

  keypad_pu_a: assert property (##1 pd_pins.pull_en == // R14
    ($past(port_d_keypad_irq_enable_reg_r) & ~$past(pd_pins.oe)))
    else $error("port d keypad pull-up wrong");

  keypad_en_a: assert property (wr_en && // R15
    addr_r == FPG_IDX_KEYPAD_EN |=> ##1
    port_d_keypad_irq_enables == $past(hwdata[7:0], 2))
    else $error("keypad enables not passed on");

  portc_upper_a: assert property (rd_now && // R16
    haddr[FPG_IDX_LSB +: 6] == FPG_IDX_PORT_C_DIR |=> hrdata[7:5] == 3'h0)
    else $error("port c upper bits not zero");

  dir_read_a: assert property (rd_now && // R17
    haddr[FPG_IDX_LSB +: 6] == FPG_IDX_PORT_D_DIR |=>
    hrdata[7:0] == $past(pd_pins.oe))
    else $error("direction readback wrong");

  stall_len_a: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");

  write_cov: cover property (wr_en && addr_r == FPG_IDX_PORT_A_LATCH);
  stall_cov: cover property (st_r == FPG_ST_STALL);
  pin_read_cov: cover property (rd_now && pd_pins.oe == 8'h00 &&
    haddr[FPG_IDX_LSB +: 6] == FPG_IDX_PORT_D_LATCH);
  keypad_cov: cover property (pd_pins.pull_en != 8'h00);

endmodule : fpg_top

// file: fpg_top_tb.sv
// fpg_top_tb: self-checking bench for the four-port gpio
`timescale 1ns/100ps
module fpg_top_tb;
  import fpg_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [7:0] pa_lvl, pb_lvl, pd_lvl;
  logic [4:0] pc_lvl;
  fpg_pin8_t pa_pins, pb_pins, pd_pins;
  fpg_pin5_t pc_pins;
  logic led_drive_select;
  logic [7:0] port_d_keypad_irq_enables;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0001_5010;
  logic [7:0] exp_q[$];
  logic rd_pend = 1'b0;
  logic [7:0] lat[4];
  logic [7:0] dir[4];

  always #12.5 hclk = ~hclk;

  fpg_top u_fpg_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pa_pin_in(pa_lvl),
    .pb_pin_in(pb_lvl), .pc_pin_in(pc_lvl), .pd_pin_in(pd_lvl),
    .pa_pins(pa_pins), .pb_pins(pb_pins), .pc_pins(pc_pins),
    .pd_pins(pd_pins), .led_drive_select(led_drive_select),
    .port_d_keypad_irq_enables(port_d_keypad_irq_enables));
  fpg_pin_model #(.W(8)) u_fpg_pin_model_a (.hclk(hclk),
    .out(pa_pins.out), .oe(pa_pins.oe), .pull_en(pa_pins.pull_en),
    .ext_en(ext_en), .ext_val(ext_val), .lvl(pa_lvl));
  fpg_pin_model #(.W(8)) u_fpg_pin_model_b (.hclk(hclk),
    .out(pb_pins.out), .oe(pb_pins.oe), .pull_en(pb_pins.pull_en),
    .ext_en(ext_en), .ext_val(ext_val), .lvl(pb_lvl));
  fpg_pin_model #(.W(5)) u_fpg_pin_model_c (.hclk(hclk),
    .out(pc_pins.out), .oe(pc_pins.oe), .pull_en(pc_pins.pull_en),
    .ext_en(ext_en[4:0]), .ext_val(ext_val[4:0]), .lvl(pc_lvl));
  fpg_pin_model #(.W(8)) u_fpg_pin_model_d (.hclk(hclk),
    .out(pd_pins.out), .oe(pd_pins.oe), .pull_en(pd_pins.pull_en),
    .ext_en(ext_en), .ext_val(ext_val), .lvl(pd_lvl));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic fail(input string m);
    failures++;
    $display("FAIL %0t %s", $time, m);
  endtask : fail

  task automatic cmp_rd(input logic [7:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== {24'h0, exp}) fail($sformatf("read %h exp %h", got, exp));
  endtask : cmp_rd

  task automatic cmp_pins(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("pins %h exp %h", got, exp));
  endtask : cmp_pins

  function automatic logic [23:0] got_pins(input int p);
    case (p)
      0: return pa_pins;
      1: return pb_pins;
      2: return {3'h0, pc_pins.out, 3'h0, pc_pins.oe, 3'h0, pc_pins.pull_en};
      default: return pd_pins;
    endcase
  endfunction : got_pins

  task automatic chk_port(input int p, input logic [7:0] pu);
    logic [7:0] m;
    m = (p == 2) ? 8'h1F : 8'hFF;
    cmp_pins(got_pins(p), {lat[p] & m, dir[p] & m, pu & m});
  endtask : chk_port

  // one single transfer; for a read, d is the expected byte
  task automatic bus(input logic w, input logic [5:0] idx,
                     input logic [7:0] d);
    int n;
    hsel <= 1'b1;
    haddr <= {24'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= w ? {24'h0, d} : 32'h0;
    if (!w) exp_q.push_back(d);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
  endtask : bus

  // ----------------------------------------
  // read monitor and watchdog
  // ----------------------------------------
  always @(posedge hclk) begin
    if (!hresetn) rd_pend = 1'b0;
    else begin
      if (rd_pend && hreadyout === 1'b1) begin
        if (exp_q.size() == 0) fail("read data with no expectation");
        else cmp_rd(exp_q.pop_front(), hrdata);
        rd_pend = 1'b0;
      end
      if (hsel && htrans[1] && hreadyout && !hwrite) rd_pend = 1'b1;
    end
  end

  always @(posedge hclk) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [7:0] v;
    logic [7:0] m;
    logic [7:0] kp;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int p = 0; p < 4; p++) begin
      dir[p] = 8'h00;
      cmp_pins(got_pins(p) & 24'h00_FFFF, 24'h0);
    end
    cmp_pins({15'h0, led_drive_select, port_d_keypad_irq_enables},
             24'h00_0100);
    bus(1'b0, FPG_IDX_OPTION, FPG_OPT_RESET);
    ext_en <= 8'hFF;
    for (int k = 0; k < 3; k++) begin
      for (int p = 0; p < 4; p++) begin
        m = (p == 2) ? 8'h1F : 8'hFF;
        seed = lfsr(seed);
        lat[p] = seed[7:0];
        bus(1'b1, FPG_IDX_PORT_A_LATCH + 6'(p), lat[p]);
        seed = lfsr(seed);
        dir[p] = seed[15:8] & m;
        bus(1'b1, FPG_IDX_PORT_A_DIR + 6'(p), seed[15:8]);
        v = seed[23:16];
        ext_val <= v;
        repeat (4) @(posedge hclk);
        chk_port(p, 8'h00);
        bus(1'b0, FPG_IDX_PORT_A_DIR + 6'(p), dir[p]);
        bus(1'b0, FPG_IDX_PORT_A_LATCH + 6'(p),
            ((lat[p] & dir[p]) | (v & ~dir[p])) & m);
      end
    end
    // pull-ups: external drive removed so inputs rest on them
    ext_en <= 8'h00;
    seed = lfsr(seed);
    kp = seed[7:0];
    bus(1'b1, FPG_IDX_OPTION, 8'hFF);
    bus(1'b1, FPG_IDX_KEYPAD_EN, kp);
    bus(1'b0, FPG_IDX_OPTION, FPG_OPT_MASK);
    repeat (4) @(posedge hclk);
    for (int p = 0; p < 4; p++) begin
      m = (p == 2) ? 8'h1F : 8'hFF;
      chk_port(p, (p == 3) ? (kp & ~dir[p]) : ~dir[p]);
      if (p < 3)
        bus(1'b0, FPG_IDX_PORT_A_LATCH + 6'(p),
            ((lat[p] & dir[p]) | ~dir[p]) & m);
    end
    cmp_pins({15'h0, led_drive_select, port_d_keypad_irq_enables},
             {15'h0, 1'b1, kp});
    bus(1'b1, FPG_IDX_OPTION, 8'h00);
    repeat (3) @(posedge hclk);
    for (int p = 0; p < 3; p++) chk_port(p, 8'h00);
    cmp_pins({15'h0, led_drive_select, port_d_keypad_irq_enables},
             {15'h0, 1'b0, kp});
    // unmapped place: write dropped, reads zero
    bus(1'b1, 6'h10, 8'hA5);
    bus(1'b0, 6'h10, 8'h00);
    // second reset: directions clear, latches survive
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int p = 0; p < 4; p++) begin
      dir[p] = 8'h00;
      chk_port(p, 8'h00);
      bus(1'b0, FPG_IDX_PORT_A_DIR + 6'(p), 8'h00);
    end
    cmp_pins({15'h0, led_drive_select, port_d_keypad_irq_enables},
             24'h00_0100);
    repeat (2) @(posedge hclk);
    tally_and_finish();
  end
endmodule : fpg_top_tb
